// [xtalk_tcoef_overload_regs.sv]
// Crosstalk temperature coefficient, overload threshold and temperature conversion registers

// Summary of operation
// - 0x60 holds ch1 high, ch1 low, ch0 high
// - 0x61 holds ch2 high, ch2 low; top reserved
// - Upper threshold select 23:21, codes 0-2, reset 1
// - Lower threshold select 20:18, codes 0,2, reset 2
// - 0x65 bit 23 disables overload detection
// - Reset loads 0x280C00, 0x20000, others zero
// - 0x6E bit 19 enables temperature conversion
module xtalk_tcoef_overload_regs (
  input  wire logic                               clock,                     // 125 MHz system clock
  input  wire logic                               rst_n,                     // Asynchronous reset, active low
  input  wire logic                               regWrite,                  // Write strobe, one cycle
  input  wire logic                               regRead,                   // Read strobe, one cycle
  input  wire logic [tof_cfg_pkg::ADDR_W-1:0]     regAddr,                   // Register offset
  input  wire logic [tof_cfg_pkg::DATA_W-1:0]     regWriteData,              // Write value
  output logic      [tof_cfg_pkg::DATA_W-1:0]     readData,                  // Read value, zero if unmapped
  output logic                                    readValid,                 // Read answer pulse
  output logic                                    readError,                 // Read hit no register
  output logic      [tof_cfg_pkg::COEF_W-1:0]     qcoefCh1High,              // Ch1 high-current coefficient
  output logic      [tof_cfg_pkg::COEF_W-1:0]     qcoefCh1Low,               // Ch1 low-current coefficient
  output logic      [tof_cfg_pkg::COEF_W-1:0]     qcoefCh0High,              // Ch0 high-current coefficient
  output logic      [tof_cfg_pkg::COEF_W-1:0]     qcoefCh2High,              // Ch2 high-current coefficient
  output logic      [tof_cfg_pkg::COEF_W-1:0]     qcoefCh2Low,               // Ch2 low-current coefficient
  output logic      [tof_cfg_pkg::SEL_W-1:0]      overloadUpperThresholdSel, // Upper comparator threshold code
  output logic      [tof_cfg_pkg::SEL_W-1:0]      overloadLowerThresholdSel, // Lower comparator threshold code
  output logic                                    overloadDetectDisable,     // High disables overload detection
  output logic                                    tempConversionEnable,      // High enables temperature conversion
  output logic                                    upperSelInvalid,           // Upper code is not a valid code
  output logic                                    lowerSelInvalid            // Lower code is not a valid code
);

  logic [tof_cfg_pkg::DATA_W-1:0] regValue [tof_cfg_pkg::NUM_REGS];
  logic [tof_cfg_pkg::DATA_W-1:0] readDataNext;
  logic                           readHitNext;

  // One cell per register; reserved bits are kept so read-back is exact
  for (genvar i = 0; i < tof_cfg_pkg::NUM_REGS; i++)
  begin : g_regs
    cfg_reg_cell #(
      .WIDTH       (tof_cfg_pkg::DATA_W),
      .RESET_VALUE (tof_cfg_pkg::REG_RESET[i])
    ) u_cell (
      .clock       (clock),
      .rst_n       (rst_n),
      .writeEnable (regWrite && (regAddr == tof_cfg_pkg::REG_OFFSET[i])),
      .writeData   (regWriteData),
      .value       (regValue[i])
    );
  end

  // Field taps come straight off the register cells
  assign qcoefCh1High = regValue[tof_cfg_pkg::IDX_COEF_A][tof_cfg_pkg::POS_CH1_HIGH +: tof_cfg_pkg::COEF_W];
  assign qcoefCh1Low  = regValue[tof_cfg_pkg::IDX_COEF_A][tof_cfg_pkg::POS_CH1_LOW +: tof_cfg_pkg::COEF_W];
  assign qcoefCh0High = regValue[tof_cfg_pkg::IDX_COEF_A][tof_cfg_pkg::POS_CH0_HIGH +: tof_cfg_pkg::COEF_W];
  assign qcoefCh2High = regValue[tof_cfg_pkg::IDX_COEF_B][tof_cfg_pkg::POS_CH2_HIGH +: tof_cfg_pkg::COEF_W];
  assign qcoefCh2Low  = regValue[tof_cfg_pkg::IDX_COEF_B][tof_cfg_pkg::POS_CH2_LOW +: tof_cfg_pkg::COEF_W];
  assign overloadUpperThresholdSel =
    regValue[tof_cfg_pkg::IDX_THRESH][tof_cfg_pkg::POS_UPPER_SEL +: tof_cfg_pkg::SEL_W];
  assign overloadLowerThresholdSel =
    regValue[tof_cfg_pkg::IDX_THRESH][tof_cfg_pkg::POS_LOWER_SEL +: tof_cfg_pkg::SEL_W];
  assign overloadDetectDisable = regValue[tof_cfg_pkg::IDX_OVLCTL][tof_cfg_pkg::POS_OVL_DISABLE];
  assign tempConversionEnable  = regValue[tof_cfg_pkg::IDX_TEMPCTL][tof_cfg_pkg::POS_TEMP_CONV_EN];

  // Invalid codes are still stored and passed on; the flags only report them
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      upperSelInvalid <= 1'b0;
    else
      upperSelInvalid <= !((overloadUpperThresholdSel == tof_cfg_pkg::UPPER_SEL_DEFAULT) ||
                           (overloadUpperThresholdSel == tof_cfg_pkg::UPPER_SEL_100MV) ||
                           (overloadUpperThresholdSel == tof_cfg_pkg::UPPER_SEL_200MV));
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lowerSelInvalid <= 1'b0;
    else
      lowerSelInvalid <= !((overloadLowerThresholdSel == tof_cfg_pkg::LOWER_SEL_DEFAULT) ||
                           (overloadLowerThresholdSel == tof_cfg_pkg::LOWER_SEL_NEG100MV));
  end

  // Read decode; a same-cycle write is not yet visible to the read
  always_comb
  begin
    readDataNext = '0;
    readHitNext  = 1'b0;
    for (int i = 0; i < tof_cfg_pkg::NUM_REGS; i++)
    begin
      if (regAddr == tof_cfg_pkg::REG_OFFSET[i])
      begin
        readDataNext = regValue[i];
        readHitNext  = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readData  <= '0;
      readValid <= 1'b0;
      readError <= 1'b0;
    end
    else
    begin
      readValid <= regRead;
      readError <= regRead && !readHitNext;
      if (regRead)
        readData <= readDataNext;
    end
  end

  property p_coef_a_fields;
    @(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == tof_cfg_pkg::OFF_COEF_A) |=>
      (qcoefCh1High == $past(regWriteData[23:16])) && (qcoefCh1Low == $past(regWriteData[15:8])) &&
      (qcoefCh0High == $past(regWriteData[7:0]));
  endproperty
  a_coef_a_fields: assert property (p_coef_a_fields) else $error("coefficient register A fields wrong");

  property p_coef_b_fields;
    @(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == tof_cfg_pkg::OFF_COEF_B) |=>
      (qcoefCh2High == $past(regWriteData[15:8])) && (qcoefCh2Low == $past(regWriteData[7:0]));
  endproperty
  a_coef_b_fields: assert property (p_coef_b_fields) else $error("coefficient register B fields wrong");

  property p_upper_sel;
    @(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == tof_cfg_pkg::OFF_THRESH) |=>
      (overloadUpperThresholdSel == $past(regWriteData[23:21])) ##1
      (upperSelInvalid == ($past(regWriteData[23:21], 2) > 3'h2));
  endproperty
  a_upper_sel: assert property (p_upper_sel) else $error("upper threshold select or flag wrong");

  property p_lower_sel;
    @(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == tof_cfg_pkg::OFF_THRESH) |=>
      (overloadLowerThresholdSel == $past(regWriteData[20:18])) ##1
      (lowerSelInvalid == !($past(regWriteData[20:18], 2) inside {3'h0, 3'h2}));
  endproperty
  a_lower_sel: assert property (p_lower_sel) else $error("lower threshold select or flag wrong");

  property p_ovl_disable;
    @(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == tof_cfg_pkg::OFF_OVLCTL) |=> (overloadDetectDisable == $past(regWriteData[23]));
  endproperty
  a_ovl_disable: assert property (p_ovl_disable) else $error("overload disable bit wrong");

  property p_reset_values;
    @(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> (overloadUpperThresholdSel == 3'h1) && (overloadLowerThresholdSel == 3'h2) &&
      !overloadDetectDisable && !tempConversionEnable && (qcoefCh1High == 8'h00) && (qcoefCh2Low == 8'h00);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_temp_enable;
    @(posedge clock) disable iff (!rst_n)
    (regWrite && regAddr == tof_cfg_pkg::OFF_TEMPCTL) |=> (tempConversionEnable == $past(regWriteData[19]));
  endproperty
  a_temp_enable: assert property (p_temp_enable) else $error("temperature conversion enable wrong");

  property p_write_read_back;
    @(posedge clock) disable iff (!rst_n)
    (regWrite && !regRead && regAddr == tof_cfg_pkg::OFF_THRESH) ##1
      (regRead && !regWrite && regAddr == tof_cfg_pkg::OFF_THRESH) |=>
      readValid && !readError && (readData == $past(regWriteData, 2));
  endproperty
  a_write_read_back: assert property (p_write_read_back) else $error("read-back differs from write");

  property p_unmapped_read;
    @(posedge clock) disable iff (!rst_n)
    (regRead && !(regAddr inside {8'h60, 8'h61, 8'h64, 8'h65, 8'h6e})) |=>
      readValid && readError && (readData == 24'h000000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read answer wrong");

  property p_read_answer;
    @(posedge clock) disable iff (!rst_n)
    regRead |=> readValid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read strobe got no answer pulse");

  property p_read_quiet;
    @(posedge clock) disable iff (!rst_n)
    !regRead |=> !readValid && !readError;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("answer pulse without a read strobe");

  // Read data stands until the next read so a slow host still catches it
  property p_read_data_holds;
    @(posedge clock) disable iff (!rst_n)
    !regRead |=> $stable(readData);
  endproperty
  a_read_data_holds: assert property (p_read_data_holds) else $error("read data moved without a read");

  property p_unmapped_write;
    @(posedge clock) disable iff (!rst_n)
    (regWrite && !(regAddr inside {8'h60, 8'h61, 8'h64, 8'h65, 8'h6e})) |=>
      $stable({qcoefCh1High, qcoefCh1Low, qcoefCh0High, qcoefCh2High, qcoefCh2Low, overloadUpperThresholdSel,
               overloadLowerThresholdSel, overloadDetectDisable, tempConversionEnable});
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a field");

  property p_upper_flag_track;
    @(posedge clock) disable iff (!rst_n)
    upperSelInvalid == !($past(overloadUpperThresholdSel) inside {3'h0, 3'h1, 3'h2});
  endproperty
  a_upper_flag_track: assert property (p_upper_flag_track) else $error("upper invalid flag wrong");

  property p_lower_flag_track;
    @(posedge clock) disable iff (!rst_n)
    lowerSelInvalid == !($past(overloadLowerThresholdSel) inside {3'h0, 3'h2});
  endproperty
  a_lower_flag_track: assert property (p_lower_flag_track) else $error("lower invalid flag wrong");

endmodule

// [tof_cfg_pkg.sv]
// Shared constants for the crosstalk coefficient and overload configuration bank
package tof_cfg_pkg;

  localparam int unsigned DATA_W = 24;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_REGS = 5;

  // Register indices inside the bank
  localparam int unsigned IDX_COEF_A = 0;
  localparam int unsigned IDX_COEF_B = 1;
  localparam int unsigned IDX_THRESH = 2;
  localparam int unsigned IDX_OVLCTL = 3;
  localparam int unsigned IDX_TEMPCTL = 4;

  // Register offsets on the control interface
  localparam logic [ADDR_W-1:0] OFF_COEF_A = 8'h60;
  localparam logic [ADDR_W-1:0] OFF_COEF_B = 8'h61;
  localparam logic [ADDR_W-1:0] OFF_THRESH = 8'h64;
  localparam logic [ADDR_W-1:0] OFF_OVLCTL = 8'h65;
  localparam logic [ADDR_W-1:0] OFF_TEMPCTL = 8'h6e;

  // Reset values
  localparam logic [DATA_W-1:0] RST_COEF_A = 24'h000000;
  localparam logic [DATA_W-1:0] RST_COEF_B = 24'h000000;
  localparam logic [DATA_W-1:0] RST_THRESH = 24'h280c00;
  localparam logic [DATA_W-1:0] RST_OVLCTL = 24'h000000;
  localparam logic [DATA_W-1:0] RST_TEMPCTL = 24'h020000;

  localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REGS] = '{OFF_COEF_A, OFF_COEF_B, OFF_THRESH, OFF_OVLCTL, OFF_TEMPCTL};
  localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{RST_COEF_A, RST_COEF_B, RST_THRESH, RST_OVLCTL, RST_TEMPCTL};

  // Coefficient byte positions (low bit of each byte)
  localparam int unsigned COEF_W = 8;
  localparam int unsigned POS_CH1_HIGH = 16;
  localparam int unsigned POS_CH1_LOW = 8;
  localparam int unsigned POS_CH0_HIGH = 0;
  localparam int unsigned POS_CH2_HIGH = 8;
  localparam int unsigned POS_CH2_LOW = 0;

  // Overload threshold fields
  localparam int unsigned SEL_W = 3;
  localparam int unsigned POS_UPPER_SEL = 21;
  localparam int unsigned POS_LOWER_SEL = 18;
  localparam logic [SEL_W-1:0] UPPER_SEL_DEFAULT = 3'h0;
  localparam logic [SEL_W-1:0] UPPER_SEL_100MV = 3'h1;
  localparam logic [SEL_W-1:0] UPPER_SEL_200MV = 3'h2;
  localparam logic [SEL_W-1:0] LOWER_SEL_DEFAULT = 3'h0;
  localparam logic [SEL_W-1:0] LOWER_SEL_NEG100MV = 3'h2;

  // Single-bit controls
  localparam int unsigned POS_OVL_DISABLE = 23;
  localparam int unsigned POS_TEMP_CONV_EN = 19;

endpackage

// [cfg_reg_cell.sv]
// One read/write configuration register with a fixed reset value
module cfg_reg_cell #(
  parameter int unsigned          WIDTH       = 24,
  parameter logic [WIDTH-1:0]     RESET_VALUE = '0
) (
  input  wire logic               clock,        // System clock
  input  wire logic               rst_n,        // Asynchronous reset, active low
  input  wire logic               writeEnable,  // Load writeData this cycle
  input  wire logic [WIDTH-1:0]   writeData,    // Full-width write value
  output logic      [WIDTH-1:0]   value         // Stored value
);

  // Reserved bits are stored as written so read-back matches the last write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      value <= RESET_VALUE;
    else if (writeEnable)
      value <= writeData;
  end

endmodule

// [host_model.sv]
// Host model that programs the configuration bank through its register port
module host_model (
  input  wire logic                           clock,        // System clock
  input  wire logic [tof_cfg_pkg::DATA_W-1:0] readData,     // Read value
  input  wire logic                           readValid,    // Read answer pulse
  input  wire logic                           readError,    // Unmapped read flag
  output logic                                regWrite,     // Write strobe
  output logic                                regRead,      // Read strobe
  output logic      [tof_cfg_pkg::ADDR_W-1:0] regAddr,      // Register offset
  output logic      [tof_cfg_pkg::DATA_W-1:0] regWriteData  // Write value
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWriteData = 24'h000000;
  end

  // Reserved bits go out exactly as the caller gives them, with no masking to fixed values
  task automatic write_reg(input logic [tof_cfg_pkg::ADDR_W-1:0] addr, input logic [tof_cfg_pkg::DATA_W-1:0] data);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= addr;
    regWriteData <= data;
    @(posedge clock);
    regWrite <= 1'b0;
    // Idle bus shows inverted values so a stale address or data can never pass for a fresh one
    regAddr <= ~addr;
    regWriteData <= ~data;
  endtask

  task automatic read_reg(input logic [tof_cfg_pkg::ADDR_W-1:0] addr, output logic [tof_cfg_pkg::DATA_W-1:0] data,
                          output logic valid, output logic err);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= addr;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~addr;
    // The answer stands for the one cycle after the strobe is taken
    @(posedge clock);
    data = readData;
    valid = readValid;
    err = readError;
  endtask

  // Write then read back on the very next edge, the tightest sequence a host can issue
  task automatic write_read_reg(input logic [tof_cfg_pkg::ADDR_W-1:0] addr,
                                input logic [tof_cfg_pkg::DATA_W-1:0] wdata,
                                output logic [tof_cfg_pkg::DATA_W-1:0] data, output logic valid, output logic err);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= addr;
    regWriteData <= wdata;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~addr;
    regWriteData <= ~wdata;
    @(posedge clock);
    data = readData;
    valid = readValid;
    err = readError;
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the crosstalk coefficient and overload configuration bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        regWrite;
  logic        regRead;
  logic [7:0]  regAddr;
  logic [23:0] regWriteData;
  logic [23:0] readData;
  logic        readValid;
  logic        readError;
  logic [7:0]  qcoefCh1High;
  logic [7:0]  qcoefCh1Low;
  logic [7:0]  qcoefCh0High;
  logic [7:0]  qcoefCh2High;
  logic [7:0]  qcoefCh2Low;
  logic [2:0]  upperSel;
  logic [2:0]  lowerSel;
  logic        overloadDetectDisable;
  logic        tempConversionEnable;
  logic        upperSelInvalid;
  logic        lowerSelInvalid;
  int          err_total = 0;
  int          total_checks = 0;
  int          cycleCount = 0;

  always #4 clock = ~clock;

  host_model u_host (.clock(clock), .readData(readData), .readValid(readValid), .readError(readError),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData));

  xtalk_tcoef_overload_regs uut (.clock(clock), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData), .readData(readData), .readValid(readValid),
    .readError(readError), .qcoefCh1High(qcoefCh1High), .qcoefCh1Low(qcoefCh1Low), .qcoefCh0High(qcoefCh0High),
    .qcoefCh2High(qcoefCh2High), .qcoefCh2Low(qcoefCh2Low), .overloadUpperThresholdSel(upperSel),
    .overloadLowerThresholdSel(lowerSel), .overloadDetectDisable(overloadDetectDisable),
    .tempConversionEnable(tempConversionEnable), .upperSelInvalid(upperSelInvalid),
    .lowerSelInvalid(lowerSelInvalid));

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [23:0] exp, input logic err);
    logic [23:0] val;
    logic        vld;
    logic        bad;
    u_host.read_reg(addr, val, vld, bad);
    chk(24'({bad, vld}), 24'({err, 1'b1}));
    chk(val, exp);
  endtask

  task automatic wr_rd_chk(input logic [7:0] addr, input logic [23:0] data);
    logic [23:0] val;
    logic        vld;
    logic        bad;
    u_host.write_read_reg(addr, data, val, vld, bad);
    chk(24'({bad, vld}), 24'h000001);
    chk(val, data);
  endtask

  // Invalid-code flags trail the field by one more cycle, so wait one edge past the write
  task automatic settle;
    @(posedge clock);
    #1;
  endtask

  task automatic check_reset_values;
    for (int i = 0; i < tof_cfg_pkg::NUM_REGS; i++)
      rd_chk(tof_cfg_pkg::REG_OFFSET[i], tof_cfg_pkg::REG_RESET[i], 1'b0);
    chk(24'({upperSel, lowerSel, overloadDetectDisable, tempConversionEnable}), 24'({3'h1, 3'h2, 2'b00}));
  endtask

  always @(posedge clock)
  begin
    cycleCount++;
    if (cycleCount == 5000)
    begin
      err_total++;
      close_out();
    end
  end

  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    check_reset_values();
    u_host.write_reg(tof_cfg_pkg::OFF_COEF_A, 24'ha5c33c);
    u_host.write_reg(tof_cfg_pkg::OFF_COEF_B, 24'h007e81);
    settle();
    chk(24'({qcoefCh1High, qcoefCh1Low, qcoefCh0High}), 24'ha5c33c);
    chk(24'({qcoefCh2High, qcoefCh2Low}), 24'h007e81);
    rd_chk(tof_cfg_pkg::OFF_COEF_A, 24'ha5c33c, 1'b0);
    rd_chk(tof_cfg_pkg::OFF_COEF_B, 24'h007e81, 1'b0);
    // Every code on both threshold fields, valid ones and invalid ones
    for (int c = 0; c < 8; c++)
    begin
      u_host.write_reg(tof_cfg_pkg::OFF_THRESH, {c[2:0], c[2:0], 18'h00c00});
      settle();
      chk(24'({upperSel, lowerSel, upperSelInvalid, lowerSelInvalid}), 24'({c[2:0], c[2:0], c > 2, c != 0 && c != 2}));
      rd_chk(tof_cfg_pkg::OFF_THRESH, {c[2:0], c[2:0], 18'h00c00}, 1'b0);
    end
    wr_rd_chk(tof_cfg_pkg::OFF_THRESH, 24'h000c00);
    for (int b = 1; b >= 0; b--)
    begin
      u_host.write_reg(tof_cfg_pkg::OFF_OVLCTL, {b[0], 23'h000000});
      u_host.write_reg(tof_cfg_pkg::OFF_TEMPCTL, {4'h0, b[0], 19'h20000});
      settle();
      chk(24'({overloadDetectDisable, tempConversionEnable}), 24'({b[0], b[0]}));
      rd_chk(tof_cfg_pkg::OFF_OVLCTL, {b[0], 23'h000000}, 1'b0);
      rd_chk(tof_cfg_pkg::OFF_TEMPCTL, {4'h0, b[0], 19'h20000}, 1'b0);
    end
    u_host.write_reg(8'h62, 24'h123456);
    rd_chk(8'h62, 24'h000000, 1'b1);
    rd_chk(tof_cfg_pkg::OFF_COEF_A, 24'ha5c33c, 1'b0);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    check_reset_values();
    close_out();
  end
endmodule
